// file: hdl/mce_pkg.sv
package mce_pkg;
	// ==========================================
	// channels and data
	localparam int CH_N = 4;
	localparam int DW = 24;
	localparam int AC_SPAN = 6;
	localparam logic [5:0] DIV_LAST = 6'h2f;
	typedef enum logic [1:0] {MCE_DCOFF, MCE_ACOFF, MCE_DCGAIN, MCE_ACGAIN} mce_op_t;
	// ==========================================
	// device register indices
	localparam logic [2:0] RA_GAIN_GRP = 3'h0;
	localparam logic [2:0] RA_DCOFF_GRP = 3'h1;
	localparam logic [2:0] RA_ACOFF_GRP = 3'h2;
	localparam logic [4:0] RA_GAIN = 5'h00;
	localparam logic [4:0] RA_ACOFF = 5'h08;
	localparam logic [4:0] RA_CYCLES = 5'h0c;
	localparam logic [4:0] RA_SETTLE = 5'h0d;
	localparam logic [4:0] RA_STATUS = 5'h0e;
	// ==========================================
	// status bits
	localparam int ST_READY = 0;
	localparam int ST_INST_OR = 1;
	localparam int ST_RMS_OR = 5;
	// ==========================================
	// values
	localparam logic [23:0] GAIN_UNITY = 24'h400000;
	localparam logic [23:0] SETTLE_RST = 24'h00001e;
	localparam logic [23:0] CYCLES_RST = 24'h0003e8;
	localparam logic [23:0] POS_FULL = 24'h7fffff;
	localparam logic [23:0] NEG_FULL = 24'h800000;
	localparam logic [23:0] GAIN_MAX = 24'hffffff;
	localparam logic [47:0] RECIP_NUM = 48'h200000000000;
	localparam logic [47:0] AC_NUM = 48'h133333333333;
	// ==========================================
	// host user registers
	localparam logic [2:0] HA_CMD = 3'h0;
	localparam logic [2:0] HA_ADDR = 3'h1;
	localparam logic [2:0] HA_DATA = 3'h2;
	localparam logic [2:0] HA_FETCH = 3'h3;
	localparam logic [2:0] HA_PRESET = 3'h4;
endpackage

// file: hdl/mce_link_if.sv
`timescale 1ns/100ps
interface mce_link_if;
	logic [4:0] regAddr;
	logic [23:0] regWdata;
	logic regWr;
	logic regRd;
	logic [23:0] regRdata;
	logic cmdValid;
	mce_pkg::mce_op_t cmdOp;
	logic [3:0] cmdMask;
	logic devReady;
	modport dev (input regAddr, regWdata, regWr, regRd, cmdValid, cmdOp, cmdMask, output regRdata, devReady);
	modport host (output regAddr, regWdata, regWr, regRd, cmdValid, cmdOp, cmdMask, input regRdata, devReady);
endinterface

// file: hdl/mce_device.sv
// Functional notes
// RULE_01 - separate offset and gain per channel
// RULE_02 - average exactly cycle-count samples
// RULE_03 - dc calibrations span settle plus count
// RULE_04 - ac offset spans six counts plus settle
// RULE_05 - completion sets conversion ready flag
// RULE_06 - overrange sets instantaneous or rms flags
// RULE_07 - dc offset stores negated average
// RULE_08 - dc offset added to later samples
// RULE_09 - ac offset stores negated rms, added later
// RULE_10 - host presets unity gain before dc offset
// RULE_11 - host clears ac offset before ac offset
// RULE_12 - host uses dc reference, filter off
// RULE_13 - host reference between quarter and full scale
// RULE_14 - ac gain stores 0.6 over rms
// RULE_15 - dc gain stores reciprocal, used later
// RULE_16 - host presets gain for ac gain
// RULE_17 - host keeps offset, gain, ac offset order
// RULE_18 - host commands only while device ready
// RULE_19 - discard settle samples first, reset thirty
// RULE_20 - touch only selected channels, clear sums
`timescale 1ns/100ps
module mce_device (
	input wire logic clk,
	input wire logic rst_b,
	mce_link_if.dev link,
	input wire logic sampleStrobe,
	input wire logic [3:0][23:0] sampleIn,
	input wire logic [3:0][23:0] rmsIn,
	output logic [3:0][23:0] sampleOut,
	output logic [3:0][23:0] rmsOut,
	output logic outValid
);
	// ==========================================
	// state
	typedef enum logic [2:0] {DS_IDLE, DS_SETTLE, DS_ACCUM, DS_PICK, DS_DIV, DS_POST, DS_NEXT} mce_dev_st_t;
	typedef struct packed {
		mce_dev_st_t st;
		mce_pkg::mce_op_t op;
		logic [3:0] mask;
		logic [1:0] ch;
		logic [26:0] cnt;
		logic [3:0][47:0] sum;
		logic [5:0] divStep;
		logic [47:0] divNum;
		logic [23:0] divDen;
		logic [23:0] rem;
		logic phase;
		logic neg;
		logic [3:0][23:0] gain;
		logic [3:0][23:0] dcOff;
		logic [3:0][23:0] acOff;
		logic [23:0] cycles;
		logic [23:0] settle;
		logic [8:0] status;
		logic [23:0] rdata;
		logic [3:0][23:0] sampleOut;
		logic [3:0][23:0] rmsOut;
		logic outValid;
		logic ready;
	} mce_dev_state_t;
	mce_dev_state_t c;
	mce_dev_state_t next_c;
	logic [3:0][23:0] corrS;
	logic [3:0][23:0] corrR;
	logic [3:0][23:0] measD;

	// ==========================================
	// functions
	function automatic logic [23:0] sat24(input logic signed [49:0] v);
		if (v > 50'sd8388607)
			return mce_pkg::POS_FULL;
		else if (v < -50'sd8388608)
			return mce_pkg::NEG_FULL;
		return v[23:0];
	endfunction

	function automatic logic signed [49:0] applyGain(input logic signed [24:0] v, input logic [23:0] g);
		logic signed [49:0] p;
		p = v * $signed({1'b0, g});
		return p >>> 22;
	endfunction

	function automatic logic isFull(input logic [23:0] v);
		return (v == mce_pkg::POS_FULL) || (v == mce_pkg::NEG_FULL);
	endfunction

	function automatic logic [8:0] orBit(input mce_pkg::mce_op_t op, input logic [1:0] ch);
		logic [8:0] b;
		b = '0;
		if (op == mce_pkg::MCE_DCOFF || op == mce_pkg::MCE_DCGAIN)
			b[mce_pkg::ST_INST_OR + 32'(ch)] = 1'b1;
		else
			b[mce_pkg::ST_RMS_OR + 32'(ch)] = 1'b1;
		return b;
	endfunction

	// ==========================================
	// per-channel correction
	for (genvar g = 0; g < mce_pkg::CH_N; g++)
	begin : g_ch
		assign corrS[g] = sat24(applyGain($signed({sampleIn[g][23], sampleIn[g]}) + $signed({c.dcOff[g][23], c.dcOff[g]}),
			c.gain[g])); // RULE_08
		assign corrR[g] = sat24(applyGain(25'($signed(rmsIn[g])), c.gain[g]) + 50'($signed(c.acOff[g]))); // RULE_09
		assign measD[g] = sat24(applyGain(25'($signed(sampleIn[g])), c.gain[g]));
	end

	// ==========================================
	// next state
	always_comb
	begin
		logic [26:0] total;
		logic [8:0] setBits;
		logic [8:0] clrBits;
		logic [23:0] avg;
		logic [24:0] r;
		logic q;
		logic [23:0] meas;
		total = (c.op == mce_pkg::MCE_ACOFF) ? 27'(c.cycles) * 27'(mce_pkg::AC_SPAN) : 27'(c.cycles); // RULE_03 RULE_04
		setBits = '0;
		clrBits = '0;
		avg = '0;
		r = {c.rem, c.divNum[47]};
		q = (r >= {1'b0, c.divDen});
		meas = '0;
		next_c = c;
		next_c.outValid = 1'b0;
		next_c.rdata = '0;
		if (sampleStrobe)
		begin
			next_c.sampleOut = corrS; // RULE_08
			next_c.rmsOut = corrR; // RULE_09
			next_c.outValid = 1'b1;
		end
		// register port, gain and offset groups indexed per channel
		if (link.regWr)
		begin
			case (link.regAddr[4:2])
				mce_pkg::RA_GAIN_GRP: next_c.gain[link.regAddr[1:0]] = link.regWdata; // RULE_01
				mce_pkg::RA_DCOFF_GRP: next_c.dcOff[link.regAddr[1:0]] = link.regWdata; // RULE_01
				mce_pkg::RA_ACOFF_GRP: next_c.acOff[link.regAddr[1:0]] = link.regWdata; // RULE_01
				default:
				begin
					if (link.regAddr == mce_pkg::RA_CYCLES)
						next_c.cycles = link.regWdata;
					if (link.regAddr == mce_pkg::RA_SETTLE)
						next_c.settle = link.regWdata;
					if (link.regAddr == mce_pkg::RA_STATUS)
						clrBits = link.regWdata[8:0];
				end
			endcase
		end
		if (link.regRd)
		begin
			case (link.regAddr[4:2])
				mce_pkg::RA_GAIN_GRP: next_c.rdata = c.gain[link.regAddr[1:0]];
				mce_pkg::RA_DCOFF_GRP: next_c.rdata = c.dcOff[link.regAddr[1:0]];
				mce_pkg::RA_ACOFF_GRP: next_c.rdata = c.acOff[link.regAddr[1:0]];
				default:
				begin
					if (link.regAddr == mce_pkg::RA_CYCLES)
						next_c.rdata = c.cycles;
					if (link.regAddr == mce_pkg::RA_SETTLE)
						next_c.rdata = c.settle;
					if (link.regAddr == mce_pkg::RA_STATUS)
						next_c.rdata = {15'h0000, c.status};
				end
			endcase
		end
		// calibration sequencer
		case (c.st)
			DS_IDLE:
			begin
				if (link.cmdValid)
				begin
					next_c.op = link.cmdOp;
					next_c.mask = link.cmdMask;
					next_c.cnt = '0;
					next_c.sum = '0; // RULE_20
					next_c.ch = '0;
					next_c.st = DS_SETTLE;
				end
			end
			DS_SETTLE:
			begin
				if (c.cnt == 27'(c.settle)) // RULE_19
				begin
					next_c.cnt = '0;
					next_c.st = DS_ACCUM;
				end
				else if (sampleStrobe)
					next_c.cnt = c.cnt + 27'd1;
			end
			DS_ACCUM:
			begin
				if (c.cnt == total)
					next_c.st = DS_PICK;
				else if (sampleStrobe)
				begin
					next_c.cnt = c.cnt + 27'd1;
					if (c.cnt >= total - 27'(c.cycles)) // RULE_02
					begin
						for (int i = 0; i < mce_pkg::CH_N; i++)
						begin
							case (c.op)
								mce_pkg::MCE_DCOFF: meas = measD[i];
								mce_pkg::MCE_DCGAIN: meas = corrS[i];
								default: meas = corrR[i];
							endcase
							if (c.mask[i])
							begin
								next_c.sum[i] = c.sum[i] + 48'($signed(meas));
								if (isFull(meas))
									setBits = setBits | orBit(c.op, 2'(i)); // RULE_06
							end
						end
					end
				end
			end
			DS_PICK:
			begin
				next_c.st = DS_NEXT;
				if (c.mask[c.ch]) // RULE_20
				begin
					next_c.neg = c.sum[c.ch][47];
					next_c.divNum = c.sum[c.ch][47] ? 48'(-c.sum[c.ch]) : c.sum[c.ch];
					next_c.divDen = c.cycles;
					next_c.rem = '0;
					next_c.divStep = '0;
					next_c.phase = 1'b0;
					next_c.st = DS_DIV;
				end
			end
			DS_DIV:
			begin
				next_c.rem = q ? 24'(r - {1'b0, c.divDen}) : r[23:0];
				next_c.divNum = {c.divNum[46:0], q};
				next_c.divStep = c.divStep + 6'd1;
				if (c.divStep == mce_pkg::DIV_LAST)
					next_c.st = DS_POST;
			end
			DS_POST:
			begin
				next_c.st = DS_NEXT;
				if (!c.phase)
				begin
					avg = (c.divNum > 48'(mce_pkg::POS_FULL)) ? mce_pkg::POS_FULL : c.divNum[23:0];
					if (c.divNum > 48'(mce_pkg::POS_FULL))
						setBits = setBits | orBit(c.op, c.ch); // RULE_06
					case (c.op)
						mce_pkg::MCE_DCOFF: next_c.dcOff[c.ch] = c.neg ? avg : 24'(-avg); // RULE_07
						mce_pkg::MCE_ACOFF: next_c.acOff[c.ch] = c.neg ? avg : 24'(-avg); // RULE_09
						default:
						begin
							if (c.neg || avg == 24'h000000)
								setBits = setBits | orBit(c.op, c.ch); // RULE_06
							else
							begin
								next_c.divNum = (c.op == mce_pkg::MCE_DCGAIN) ? mce_pkg::RECIP_NUM : mce_pkg::AC_NUM; // RULE_14 RULE_15
								next_c.divDen = avg;
								next_c.rem = '0;
								next_c.divStep = '0;
								next_c.phase = 1'b1;
								next_c.st = DS_DIV;
							end
						end
					endcase
				end
				else if (c.divNum > 48'(mce_pkg::GAIN_MAX))
				begin
					next_c.gain[c.ch] = mce_pkg::GAIN_MAX;
					setBits = setBits | orBit(c.op, c.ch); // RULE_06
				end
				else
					next_c.gain[c.ch] = c.divNum[23:0]; // RULE_14 RULE_15
			end
			DS_NEXT:
			begin
				if (c.ch == 2'd3)
				begin
					next_c.st = DS_IDLE;
					setBits[mce_pkg::ST_READY] = 1'b1; // RULE_05
				end
				else
				begin
					next_c.ch = c.ch + 2'd1;
					next_c.st = DS_PICK;
				end
			end
			default: next_c.st = DS_IDLE;
		endcase
		next_c.status = (c.status & ~clrBits) | setBits;
		next_c.ready = (next_c.st == DS_IDLE);
	end

	// ==========================================
	// registers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			c <= '0;
			c.st <= DS_IDLE;
			c.gain <= {4{mce_pkg::GAIN_UNITY}};
			c.cycles <= mce_pkg::CYCLES_RST;
			c.settle <= mce_pkg::SETTLE_RST; // RULE_19
			c.ready <= 1'b1;
		end
		else
			c <= next_c;
	end

	assign sampleOut = c.sampleOut;
	assign rmsOut = c.rmsOut;
	assign outValid = c.outValid;
	assign link.regRdata = c.rdata;
	assign link.devReady = c.ready;
endmodule // mce_device

// file: hdl/mce_host.sv
`timescale 1ns/100ps
module mce_host (
	input wire logic clk,
	input wire logic rst_b,
	mce_link_if.host link,
	input wire logic [2:0] addr,
	input wire logic [23:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [23:0] rdata
);
	// ==========================================
	// state
	typedef enum logic [1:0] {HS_IDLE, HS_PREP, HS_ISSUE, HS_WAIT} mce_host_st_t;
	typedef struct packed {
		mce_host_st_t st;
		logic hold;
		mce_pkg::mce_op_t op;
		logic [3:0] mask;
		logic [1:0] ch;
		logic [3:0] offDone;
		logic [3:0] gainDone;
		logic refused;
		logic [23:0] preset;
		logic [4:0] devAddr;
		logic [23:0] fetched;
		logic [1:0] rdPend;
		logic [23:0] rdata;
		logic [4:0] regAddr;
		logic [23:0] regWdata;
		logic regWr;
		logic regRd;
		logic cmdValid;
	} mce_host_state_t;
	mce_host_state_t c;
	mce_host_state_t next_c;

	// ==========================================
	// next state
	always_comb
	begin
		logic ok;
		ok = 1'b1;
		next_c = c;
		next_c.regWr = 1'b0;
		next_c.regRd = 1'b0;
		next_c.cmdValid = 1'b0;
		next_c.rdata = '0;
		next_c.rdPend = {c.rdPend[0], 1'b0};
		if (c.rdPend[1])
			next_c.fetched = link.regRdata;
		if (rd)
		begin
			case (addr)
				mce_pkg::HA_CMD: next_c.rdata = {14'h0000, c.st != HS_IDLE, c.refused, c.gainDone, c.offDone};
				mce_pkg::HA_ADDR: next_c.rdata = {19'h00000, c.devAddr};
				mce_pkg::HA_DATA: next_c.rdata = c.fetched;
				mce_pkg::HA_PRESET: next_c.rdata = c.preset;
				default: next_c.rdata = '0;
			endcase
		end
		case (c.st)
			HS_IDLE:
			begin
				if (wr)
				begin
					case (addr)
						mce_pkg::HA_CMD:
						begin
							next_c.op = mce_pkg::mce_op_t'(wdata[1:0]);
							next_c.mask = wdata[7:4];
							case (mce_pkg::mce_op_t'(wdata[1:0]))
								mce_pkg::MCE_DCOFF: ok = 1'b1;
								mce_pkg::MCE_ACOFF: ok = (wdata[7:4] & ~c.gainDone) == 4'h0; // RULE_17
								default: ok = (wdata[7:4] & ~c.offDone) == 4'h0; // RULE_17
							endcase
							next_c.refused = !(ok && link.devReady); // RULE_18
							next_c.ch = '0;
							if (ok && link.devReady)
								next_c.st = (wdata[1:0] == 2'(mce_pkg::MCE_DCGAIN)) ? HS_ISSUE : HS_PREP; // RULE_12
						end
						mce_pkg::HA_ADDR: next_c.devAddr = wdata[4:0];
						mce_pkg::HA_DATA:
						begin
							next_c.regWr = 1'b1;
							next_c.regAddr = c.devAddr;
							next_c.regWdata = wdata;
						end
						mce_pkg::HA_FETCH:
						begin
							next_c.regRd = 1'b1;
							next_c.regAddr = c.devAddr;
							next_c.rdPend[0] = 1'b1;
						end
						mce_pkg::HA_PRESET: next_c.preset = wdata;
						default: next_c.refused = c.refused;
					endcase
				end
			end
			HS_PREP:
			begin
				if (c.mask[c.ch])
				begin
					next_c.regWr = 1'b1;
					next_c.regAddr = ((c.op == mce_pkg::MCE_ACOFF) ? mce_pkg::RA_ACOFF : mce_pkg::RA_GAIN) | 5'(c.ch);
					case (c.op)
						mce_pkg::MCE_ACOFF: next_c.regWdata = '0; // RULE_11
						mce_pkg::MCE_ACGAIN: next_c.regWdata = c.preset; // RULE_16
						default: next_c.regWdata = mce_pkg::GAIN_UNITY; // RULE_10
					endcase
				end
				if (c.ch == 2'd3)
					next_c.st = HS_ISSUE;
				else
					next_c.ch = c.ch + 2'd1;
			end
			HS_ISSUE:
			begin
				next_c.cmdValid = 1'b1;
				next_c.hold = 1'b1;
				next_c.st = HS_WAIT;
			end
			HS_WAIT:
			begin
				next_c.hold = 1'b0;
				if (!c.hold && link.devReady)
				begin
					next_c.st = HS_IDLE;
					if (c.op == mce_pkg::MCE_DCOFF)
						next_c.offDone = c.offDone | c.mask;
					else if (c.op != mce_pkg::MCE_ACOFF)
						next_c.gainDone = c.gainDone | c.mask;
				end
			end
			default: next_c.st = HS_IDLE;
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			c <= '0;
			c.st <= HS_IDLE;
			c.preset <= mce_pkg::GAIN_UNITY;
		end
		else
			c <= next_c;
	end

	assign rdata = c.rdata;
	assign link.regAddr = c.regAddr;
	assign link.regWdata = c.regWdata;
	assign link.regWr = c.regWr;
	assign link.regRd = c.regRd;
	assign link.cmdValid = c.cmdValid;
	assign link.cmdOp = c.op;
	assign link.cmdMask = c.mask;
endmodule // mce_host

// file: testbench/mce_link_checker.sv
`timescale 1ns/100ps
module mce_link_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [4:0] regAddr,
	input wire logic [23:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [23:0] regRdata,
	input wire logic cmdValid,
	input wire mce_pkg::mce_op_t cmdOp,
	input wire logic [3:0] cmdMask,
	input wire logic devReady
);
	// ==========
	// presets seen since last command
	logic [3:0] unitySeen;
	logic [3:0] clearSeen;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			unitySeen <= 4'h0;
			clearSeen <= 4'h0;
		end
		else if (cmdValid)
		begin
			unitySeen <= 4'h0;
			clearSeen <= 4'h0;
		end
		else if (regWr && regAddr[4:2] == mce_pkg::RA_GAIN_GRP)
			unitySeen[regAddr[1:0]] <= regWdata == mce_pkg::GAIN_UNITY;
		else if (regWr && regAddr[4:2] == mce_pkg::RA_ACOFF_GRP)
			clearSeen[regAddr[1:0]] <= regWdata == 24'h0;
	end
	// ==========
	// link properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_take;
		cmdValid && devReady;
	endsequence
	sequence s_busy;
		(!devReady) [*8];
	endsequence
	a_cmd_ready: assert property (cmdValid |-> devReady)
		else $error("command while engine busy");
	a_cmd_pulse: assert property (cmdValid |=> !cmdValid)
		else $error("command strobe too long");
	a_busy_after: assert property (s_take |=> s_busy)
		else $error("engine ready too soon");
	a_busy_cause: assert property ($fell(devReady) |-> $past(cmdValid))
		else $error("engine busy without command");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 24'h0)
		else $error("read data outside answer cycle");
	a_strobe_apart: assert property (!(regWr && regRd))
		else $error("write and read together");
	a_dcoff_unity: assert property (cmdValid && cmdOp == mce_pkg::MCE_DCOFF |-> (cmdMask & ~unitySeen) == 4'h0)
		else $error("dc offset without unity gain");
	a_acoff_clear: assert property (cmdValid && cmdOp == mce_pkg::MCE_ACOFF |-> (cmdMask & ~clearSeen) == 4'h0)
		else $error("ac offset without clearing");
endmodule // mce_link_checker

// file: testbench/test_measurement_calibration_engine.sv
`timescale 1ns/100ps
module test_measurement_calibration_engine;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [23:0] wdata = 24'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [23:0] rdata;
	logic sampleStrobe = 1'b0;
	logic [3:0][23:0] sampleIn = '0;
	logic [3:0][23:0] rmsIn = '0;
	logic [3:0][23:0] sampleOut;
	logic [3:0][23:0] rmsOut;
	logic outValid;
	logic [2:0] phase = 3'h0;
	int num_errors = 0;
	int n_compared = 0;
	int seed = 16514;
	int strobes = 0;
	logic [23:0] v;
	logic [23:0] g;
	logic signed [23:0] off [4];
	mce_link_if link ();
	mce_device mce_device_i (.clk(clk), .rst_b(rst_b), .link(link), .sampleStrobe(sampleStrobe), .sampleIn(sampleIn),
		.rmsIn(rmsIn), .sampleOut(sampleOut), .rmsOut(rmsOut), .outValid(outValid));
	mce_host mce_host_i (.clk(clk), .rst_b(rst_b), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	mce_link_checker mce_link_checker_i (.clk(clk), .rst_b(rst_b), .regAddr(link.regAddr), .regWdata(link.regWdata),
		.regWr(link.regWr), .regRd(link.regRd), .regRdata(link.regRdata), .cmdValid(link.cmdValid),
		.cmdOp(link.cmdOp), .cmdMask(link.cmdMask), .devReady(link.devReady));
	always #12.5 clk = ~clk;
	// ==========
	// sample strobe every eight cycles
	always @(posedge clk)
	begin
		phase <= phase + 3'h1;
		sampleStrobe <= phase == 3'h7;
		if (sampleStrobe && !link.devReady)
			strobes <= strobes + 1;
	end
	// ==========
	// expectations and bus tasks
	function automatic logic [23:0] conv(logic [23:0] a, logic [23:0] b, logic [23:0] gn, logic isRms);
		longint t;
		if (isRms)
			t = ((longint'(signed'(a)) * longint'(gn)) >>> 22) + longint'(signed'(b));
		else
			t = ((longint'(signed'(a)) + longint'(signed'(b))) * longint'(gn)) >>> 22;
		return t > 64'sh7fffff ? mce_pkg::POS_FULL : t < -64'sh800000 ? mce_pkg::NEG_FULL : t[23:0];
	endfunction
	task automatic check(string name, logic [23:0] got, logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic hwr(logic [2:0] a, logic [23:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic hrd(logic [2:0] a, output logic [23:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic dwr(logic [4:0] i, logic [23:0] d);
		hwr(mce_pkg::HA_ADDR, {19'h0, i});
		hwr(mce_pkg::HA_DATA, d);
	endtask
	task automatic dchk(string name, logic [4:0] i, logic [23:0] exp);
		logic [23:0] d;
		hwr(mce_pkg::HA_ADDR, {19'h0, i});
		hwr(mce_pkg::HA_FETCH, 24'h0);
		repeat (3) @(posedge clk);
		hrd(mce_pkg::HA_DATA, d);
		check(name, d, exp);
	endtask
	task automatic run(mce_pkg::mce_op_t op, logic [3:0] m, int minSpan);
		logic [23:0] d;
		int s0;
		s0 = strobes;
		hwr(mce_pkg::HA_CMD, {16'h0, m, 2'h0, op});
		repeat (2) @(posedge clk);
		d = 24'h200;
		for (int k = 0; k < 3000 && d[9]; k++)
			hrd(mce_pkg::HA_CMD, d);
		check("busy", d & 24'h200, 24'h0);
		check("span", {23'h0, strobes - s0 >= minSpan}, 24'h1);
	endtask
	task automatic waitOut;
		repeat (2)
		begin
			@(negedge clk);
			for (int k = 0; k < 20 && outValid !== 1'b1; k++)
				@(negedge clk);
		end
	endtask
	// ==========
	// main sequence
	initial
	begin
		logic [23:0] d;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		dchk("cycles", mce_pkg::RA_CYCLES, mce_pkg::CYCLES_RST);
		dchk("settle", mce_pkg::RA_SETTLE, mce_pkg::SETTLE_RST);
		dchk("gain", mce_pkg::RA_GAIN + 5'h3, mce_pkg::GAIN_UNITY);
		dchk("unmapped", 5'h1f, 24'h0);
		dwr(mce_pkg::RA_CYCLES, 24'h4);
		dwr(mce_pkg::RA_SETTLE, 24'h2);
		@(posedge clk);
		for (int c = 0; c < 4; c++)
		begin
			off[c] = 24'($random(seed) % 4096);
			sampleIn[c] <= off[c];
		end
		run(mce_pkg::MCE_DCOFF, 4'h7, 6);
		for (int c = 0; c < 3; c++)
			dchk("dcoff", {mce_pkg::RA_DCOFF_GRP, 2'(c)}, -off[c]);
		dchk("untouched", {mce_pkg::RA_DCOFF_GRP, 2'h3}, 24'h0);
		dchk("status", mce_pkg::RA_STATUS, 24'h1);
		v = 24'($random(seed) & 24'hfffff);
		@(posedge clk);
		sampleIn[0] <= off[0] + v;
		waitOut;
		check("sample", sampleOut[0], v);
		// ==========
		// settle samples thrown away, channel zero again
		fork
			run(mce_pkg::MCE_DCOFF, 4'h1, 6);
			begin
				do
					@(posedge clk);
				while (link.cmdValid !== 1'b1);
				sampleIn[0] <= off[0] + 24'h100000;
				for (int k = 0; k < 2; k++)
				begin
					do
						@(posedge clk);
					while (sampleStrobe !== 1'b1);
				end
				sampleIn[0] <= off[0];
			end
		join
		dchk("settle dcoff", {mce_pkg::RA_DCOFF_GRP, 2'h0}, -off[0]);
		// dc gain on channel one
		v = 24'h300000 + 24'($random(seed) & 24'hfffff);
		@(posedge clk);
		sampleIn[1] <= off[1] + v;
		run(mce_pkg::MCE_DCGAIN, 4'h2, 6);
		g = 24'(mce_pkg::RECIP_NUM / 48'(v));
		dchk("dcgain", mce_pkg::RA_GAIN + 5'h1, g);
		waitOut;
		check("gained", sampleOut[1], conv(off[1] + v, -off[1], g, 1'b0));
		// ac offset before gain is refused
		hwr(mce_pkg::HA_CMD, {16'h0, 4'h1, 2'h0, mce_pkg::MCE_ACOFF});
		hrd(mce_pkg::HA_CMD, d);
		check("refused", d & 24'h100, 24'h100);
		v = 24'($random(seed) & 24'hffff);
		@(posedge clk);
		rmsIn[1] <= v;
		run(mce_pkg::MCE_ACOFF, 4'h2, 26);
		dchk("acoff", {mce_pkg::RA_ACOFF_GRP, 2'h1}, -conv(v, 24'h0, g, 1'b1));
		waitOut;
		check("rms", rmsOut[1], 24'h0);
		// ac gain on channel zero, unity preset
		v = 24'h300000 + 24'($random(seed) & 24'hfffff);
		@(posedge clk);
		rmsIn[0] <= v;
		run(mce_pkg::MCE_ACGAIN, 4'h1, 6);
		dchk("acgain", mce_pkg::RA_GAIN, 24'(mce_pkg::AC_NUM / 48'(v)));
		// full-scale sample during summing
		@(posedge clk);
		sampleIn[3] <= mce_pkg::POS_FULL;
		run(mce_pkg::MCE_DCOFF, 4'h8, 6);
		dchk("overrange", mce_pkg::RA_STATUS, 24'h1 | (24'h1 << (mce_pkg::ST_INST_OR + 3)));
		dwr(mce_pkg::RA_STATUS, 24'h1ff);
		dchk("cleared", mce_pkg::RA_STATUS, 24'h0);
		end_sim;
	end
	initial
	begin
		#(25 * 40000);
		num_errors++;
		end_sim;
	end
endmodule // test_measurement_calibration_engine
